// File: bench/vpic_core_model.sv
// Purpose: behavioural processor core facing the request line
// Assumes: request line active low, strobes one cycle wide
// Notes: takes a vector after dly_in cycles, ends service 7 cycles later
`timescale 1ns/1ps
module vpic_core_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Core side
    input wire logic req_n_in,
    input wire logic en_in,
    input wire logic [3:0] dly_in,
    output logic vec_rd_out,
    output logic eos_out
);
    logic [3:0] wait_q;
    logic [3:0] open_q;
    logic [3:0] svc_q;
    ////////////////////////////////////////////////////////////////
    // Handler entry and exit
    always_ff @(posedge clk_in) begin
        vec_rd_out <= 1'b0;
        eos_out <= 1'b0;
        if (rst_in || !en_in) begin
            wait_q <= 4'h0;
            open_q <= 4'h0;
            svc_q <= 4'h0;
        end else if (!req_n_in && !vec_rd_out) begin
            if (wait_q == dly_in) begin
                vec_rd_out <= 1'b1;
                open_q <= open_q + 4'h1;
                svc_q <= 4'h6;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
            if (svc_q != 4'h0) begin
                svc_q <= svc_q - 4'h1;
            end else if (open_q != 4'h0) begin
                eos_out <= 1'b1;
                open_q <= open_q - 4'h1;
                svc_q <= 4'h6;
            end
        end
    end
endmodule

// File: bench/vpic_ctrl_bench.sv
// Purpose: self-checking bench of the vectored interrupt controller
// Assumes: inputs change 1 ns after the rising edge
// Notes: table rows first, then hand-written cases
`timescale 1ns/1ps
module vpic_ctrl_bench;
    import vpic_pkg::*;
    typedef struct packed {
        logic [2:0] k;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] p;
    } vpic_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fsrc = 1'b0;
    logic psrc = 1'b0;
    logic [31:2] per = 30'h0;
    logic [63:0] trig;
    logic [95:0] prio = 96'h0;
    logic [31:0] ff = 32'h0;
    logic [6:0] stb = 7'h00;
    logic [31:0] dat = 32'h0;
    logic men = 1'b0;
    logic [3:0] mdly = 4'h0;
    logic m_rd, m_eos, nreq, freq;
    logic [31:0] mask, pend;
    logic [SRC_W-1:0] cur, vec;
    logic [1:0] cls;
    int error_cnt = 0;
    int checks_done = 0;
    // Kind 0 enable, 1 disable, 2 set, 3 clear
    vpic_row_t rows [6] = '{
        '{3'h0, 32'h30, 32'h30, 32'h0},
        '{3'h2, 32'h30, 32'h30, 32'h10},
        '{3'h3, 32'h30, 32'h30, 32'h0},
        '{3'h2, 32'h1, 32'h30, 32'h1},
        '{3'h3, 32'h1, 32'h30, 32'h0},
        '{3'h1, 32'h10, 32'h20, 32'h0}};
    ////////////////////////////////////////////////////////////////
    // Design and core model
    vpic_ctrl i_dut (.clk_in(clk), .rst_in(rst), .fast_source_in(fsrc),
        .aggregate_platform_source_in(psrc), .peripheral_sources_in(per),
        .trigger_type_in(trig), .priority_level_in(prio), .fast_force_in(ff),
        .enable_cmd_wr_in(stb[0]), .disable_cmd_wr_in(stb[1]), .set_cmd_wr_in(stb[2]),
        .clear_cmd_wr_in(stb[3]), .cmd_data_in(dat), .vector_rd_in(stb[4] | m_rd),
        .fast_vector_rd_in(stb[5]), .end_of_service_wr_in(stb[6] | m_eos),
        .normal_request_n_out(nreq), .fast_request_n_out(freq),
        .mask_status_out(mask), .pending_status_out(pend),
        .current_source_out(cur), .core_line_status_out(cls), .vector_data_out(vec));
    vpic_core_model i_core (.clk_in(clk), .rst_in(rst), .req_n_in(nreq), .en_in(men),
        .dly_in(mdly), .vec_rd_out(m_rd), .eos_out(m_eos));
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    // Helpers
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input int k, input logic [31:0] d);
        stb[k] = 1'b1;
        dat = d;
        tick(1);
        stb = 7'h00;
        tick(1);
    endtask
    // Index 32 waits on the request line, others on a pending bit
    task automatic wait_for(input int b, input logic e);
        int n;
        n = 0;
        while (((b > 31) ? nreq : pend[b]) !== e && n < 8) begin
            tick(1);
            n++;
        end
        chk(32'(n < 8), 32'h1);
        if (n == 8) begin
            print_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        trig = {32{2'h3}};
        trig[11:10] = 2'h2;
        prio[9 +: 3] = 3'h5;
        prio[18 +: 6] = 6'h3F;
        prio[24 +: 3] = 3'h7;
        for (int k = 0; k < 8; k++) begin
            prio[3 * (11 + k) +: 3] = 3'(k);
        end
        tick(4);
        rst = 1'b0;
        chk(mask, 32'h0);
        chk(cls, 2'h3);
        chk(cur, 5'h00);
        for (int i = 0; i < 6; i++) begin
            cmd(int'(rows[i].k), rows[i].d);
            chk(mask, rows[i].m);
            chk(pend, rows[i].p);
        end
        cmd(0, 32'hC8);
        cmd(2, 32'h100);
        tick(3);
        chk(pend[8], 1'b1);
        chk(nreq, 1'b1);
        cmd(2, 32'h8);
        wait_for(32, 1'b0);
        cmd(4, 32'h0);
        chk(vec, 5'h03);
        chk(pend[3], 1'b0);
        chk(nreq, 1'b1);
        cmd(2, 32'hC0);
        wait_for(32, 1'b0);
        cmd(4, 32'h0);
        chk(cur, 5'h06);
        chk(pend[8:6], 3'h6);
        chk(nreq, 1'b1);
        cmd(6, 32'h0);
        chk(cur, 5'h03);
        wait_for(32, 1'b0);
        cmd(4, 32'h0);
        chk(cur, 5'h07);
        cmd(6, 32'h0);
        chk(cur, 5'h03);
        cmd(6, 32'h0);
        tick(1);
        chk(nreq, 1'b1);
        cmd(3, 32'h100);
        cmd(0, 32'h7F800);
        for (int k = 0; k < 8; k++) begin
            cmd(2, 32'h1 << (11 + k));
            wait_for(32, 1'b0);
            cmd(4, 32'h0);
            chk(cur, 32'(11 + k));
        end
        cmd(2, 32'h800);
        cmd(4, 32'h0);
        chk(cur, 5'h0B);
        cmd(2, 32'h1000);
        cmd(4, 32'h0);
        chk(cur, 5'h0C);
        cmd(6, 32'h0);
        chk(cur, 5'h12);
        for (int k = 7; k > 0; k--) begin
            cmd(6, 32'h0);
            chk(cur, 32'(10 + k));
        end
        cmd(6, 32'h0);
        ff = 32'h200;
        cmd(0, 32'h201);
        cmd(2, 32'h201);
        tick(2);
        chk({freq, nreq}, 2'h1);
        cmd(4, 32'h0);
        chk(pend[9], 1'b1);
        cmd(5, 32'h0);
        chk(pend[9:0], 10'h200);
        tick(1);
        chk(cls, 2'h1);
        cmd(3, 32'h200);
        tick(2);
        chk(freq, 1'b1);
        ff = 32'h0;
        for (int m = 0; m < 4; m++) begin
            trig[63:62] = 2'(m);
            per[31] = ~m[1];
            tick(4);
            cmd(3, 32'h8000_0000);
            chk(pend[31], 1'b0);
            per[31] = m[1];
            wait_for(31, 1'b1);
            per[31] = ~m[1];
            tick(5);
            chk(pend[31], m[0]);
        end
        cmd(3, 32'h8000_0000);
        men = 1'b1;
        cmd(0, 32'h400);
        for (int d = 0; d < 10; d += 5) begin
            mdly = 4'(d);
            cmd(2, 32'h400);
            tick(40);
            chk({pend[10], nreq}, 2'h1);
            chk(vec, 5'h0A);
        end
        cmd(2, 32'h400);
        tick(1);
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        chk(mask, 32'h0);
        chk(cls, 2'h3);
        chk(cur, 5'h00);
        chk(vec, 5'h00);
        tick(2);
        print_verdict();
    end
endmodule

// File: rtl/vpic_ctrl.sv
// Purpose: vectored priority interrupt controller, 32 sources, eight levels
// Assumes: command strobes last one cycle, one command per cycle
// Notes: disable wins over enable in the same cycle
`timescale 1ns/1ps
module vpic_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Interrupt sources
    input wire logic fast_source_in,
    input wire logic aggregate_platform_source_in,
    input wire logic [31:2] peripheral_sources_in,
    // Source configuration
    input wire logic [63:0] trigger_type_in,
    input wire logic [95:0] priority_level_in,
    input wire logic [31:0] fast_force_in,
    // Command strobes
    input wire logic enable_cmd_wr_in,
    input wire logic disable_cmd_wr_in,
    input wire logic set_cmd_wr_in,
    input wire logic clear_cmd_wr_in,
    input wire logic [31:0] cmd_data_in,
    input wire logic vector_rd_in,
    input wire logic fast_vector_rd_in,
    input wire logic end_of_service_wr_in,
    // Core request lines
    output logic normal_request_n_out,
    output logic fast_request_n_out,
    // Status
    output logic [31:0] mask_status_out,
    output logic [31:0] pending_status_out,
    output logic [vpic_pkg::SRC_W-1:0] current_source_out,
    output logic [1:0] core_line_status_out,
    output logic [vpic_pkg::SRC_W-1:0] vector_data_out
);
    import vpic_pkg::*;

    logic [31:0] raw, pend, is_edge, set_v, clr_v, cand, higher;
    logic [31:0] mask_q, mask_d;
    logic [SRC_W-1:0] cur_src_q, cur_src_d, vec_q, vec_d, best;
    logic [PRIO_W-1:0] cur_lvl_q, cur_lvl_d, best_lvl;
    logic in_srv_q, in_srv_d, take, push, pop;
    logic normal_request_n_q, normal_request_n_d, fast_request_n_q, fast_request_n_d;
    vpic_entry_t top;
    logic [DEPTH_W-1:0] depth;

    ////////////////////////////////////////////////////////////////////
    // Source stages
    assign raw = {peripheral_sources_in, aggregate_platform_source_in, fast_source_in};

    always_comb begin
        set_v = set_cmd_wr_in ? cmd_data_in : 32'h0000_0000;
        clr_v = clear_cmd_wr_in ? cmd_data_in : 32'h0000_0000;
        if (take && !fast_force_in[best]) begin
            clr_v[best] = 1'b1;
        end
        if (fast_vector_rd_in) begin
            clr_v[FAST_SRC] = 1'b1;
        end
    end

    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        vpic_src_stage #(
            .IS_EXT(EXT_SRC_MASK[g])
        ) u_stage (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .raw_in(raw[g]),
            .trig_in(trigger_type_in[2*g +: 2]),
            .set_in(set_v[g]),
            .clr_in(clr_v[g]),
            .pend_out(pend[g]),
            .is_edge_out(is_edge[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Mask
    always_comb begin
        mask_d = mask_q;
        if (enable_cmd_wr_in) begin
            mask_d = mask_d | cmd_data_in;
        end
        if (disable_cmd_wr_in) begin
            mask_d = mask_d & ~cmd_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_q <= MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Priority resolution and service state
    always_comb begin
        cand = pend & mask_q & ~fast_force_in;
        cand[FAST_SRC] = 1'b0;
        best = vpic_best(cand, priority_level_in);
        best_lvl = vpic_prio(priority_level_in, int'(best));
        take = vector_rd_in && (cand != 32'h0000_0000);
        push = take && in_srv_q;
        pop = end_of_service_wr_in && !take;
        cur_src_d = cur_src_q;
        cur_lvl_d = cur_lvl_q;
        in_srv_d = in_srv_q;
        vec_d = vec_q;
        if (take) begin
            cur_src_d = best;
            cur_lvl_d = best_lvl;
            in_srv_d = 1'b1;
            vec_d = best;
        end else if (pop) begin
            if (depth != 4'h0) begin
                cur_src_d = top[PRIO_W +: SRC_W];
                cur_lvl_d = top[PRIO_W-1:0];
            end else begin
                in_srv_d = 1'b0;
            end
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            higher[i] = cand[i] && (!in_srv_d || vpic_prio(priority_level_in, i) > cur_lvl_d);
        end
        // Taken source itself never outranks its own level
        normal_request_n_d = (higher == 32'h0000_0000);
        fast_request_n_d = !(|(pend & mask_q & (fast_force_in | 32'h0000_0001)));
    end

    vpic_stack u_stack (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .push_in(push),
        .pop_in(pop),
        .push_data_in({cur_src_q, cur_lvl_q}),
        .top_out(top),
        .depth_out(depth)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cur_src_q <= SRC_RESET;
            cur_lvl_q <= LEVEL_RESET;
            in_srv_q <= 1'b0;
            vec_q <= SRC_RESET;
            normal_request_n_q <= 1'b1;
            fast_request_n_q <= 1'b1;
        end else begin
            cur_src_q <= cur_src_d;
            cur_lvl_q <= cur_lvl_d;
            in_srv_q <= in_srv_d;
            vec_q <= vec_d;
            normal_request_n_q <= normal_request_n_d;
            fast_request_n_q <= fast_request_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign normal_request_n_out = normal_request_n_q;
    assign fast_request_n_out = fast_request_n_q;
    assign mask_status_out = mask_q;
    assign pending_status_out = pend;
    assign current_source_out = cur_src_q;
    assign core_line_status_out = {fast_request_n_q, normal_request_n_q};
    assign vector_data_out = vec_q;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_take;
        vector_rd_in && cand != 32'h0000_0000;
    endsequence

    sequence s_pop_nonempty;
        end_of_service_wr_in && !vector_rd_in && depth != 4'h0;
    endsequence

    property p_mask_enable;
        @(posedge clk_in) disable iff (rst_in)
        enable_cmd_wr_in && !disable_cmd_wr_in |=>
            (mask_status_out & $past(cmd_data_in)) == $past(cmd_data_in);
    endproperty
    a_mask_enable: assert property (p_mask_enable) else $error("enable lost");

    property p_mask_disable;
        @(posedge clk_in) disable iff (rst_in)
        disable_cmd_wr_in |=> (mask_status_out & $past(cmd_data_in)) == 32'h0000_0000;
    endproperty
    a_mask_disable: assert property (p_mask_disable) else $error("disable lost");

    property p_take_source;
        @(posedge clk_in) disable iff (rst_in)
        s_take |=> current_source_out == $past(best) && $past(mask_q[best]);
    endproperty
    a_take_source: assert property (p_take_source) else $error("wrong source");

    property p_take_level;
        @(posedge clk_in) disable iff (rst_in)
        s_take |=> cur_lvl_q == vpic_prio(priority_level_in, int'(current_source_out));
    endproperty
    a_take_level: assert property (p_take_level) else $error("wrong level");

    property p_push;
        @(posedge clk_in) disable iff (rst_in)
        s_take ##0 in_srv_q && depth < 4'h8 |=> depth == $past(depth) + 4'h1;
    endproperty
    a_push: assert property (p_push) else $error("no push");

    property p_pop;
        @(posedge clk_in) disable iff (rst_in)
        s_pop_nonempty |=> current_source_out == $past(top[PRIO_W +: SRC_W]) ##1 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("no restore");

    property p_read_drops;
        @(posedge clk_in) disable iff (rst_in)
        s_take ##0 !end_of_service_wr_in ##1 (cand & ~higher) == cand |-> normal_request_n_q;
    endproperty
    a_read_drops: assert property (p_read_drops) else $error("request held");

    property p_fast_line;
        @(posedge clk_in) disable iff (rst_in)
        pend[0] && mask_q[0] |=> !fast_request_n_out;
    endproperty
    a_fast_line: assert property (p_fast_line) else $error("fast line idle");

    property p_forced_out;
        @(posedge clk_in) disable iff (rst_in)
        (pend & mask_q & ~fast_force_in & 32'hFFFF_FFFE) == 32'h0000_0000 |=>
            normal_request_n_out;
    endproperty
    a_forced_out: assert property (p_forced_out) else $error("forced source on normal");

    property p_idle_request;
        @(posedge clk_in) disable iff (rst_in)
        !in_srv_q && !vector_rd_in && cand != 32'h0000_0000 |=> !normal_request_n_out;
    endproperty
    a_idle_request: assert property (p_idle_request) else $error("request missing");

    logic [31:0] beaten, above;

    // Independent view of the resolver for the checks below
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            beaten[i] = cand[i] && (vpic_prio(priority_level_in, i) > best_lvl
                || (vpic_prio(priority_level_in, i) == best_lvl && i < int'(best)));
            above[i] = cand[i] && vpic_prio(priority_level_in, i) > cur_lvl_q;
        end
    end

    property p_reset_state;
        @(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> core_line_status_out == 2'h3 && mask_status_out == MASK_RESET
            && current_source_out == SRC_RESET && vector_data_out == SRC_RESET;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_set_edge;
        @(posedge clk_in) disable iff (rst_in)
        set_cmd_wr_in ##1 $stable(trigger_type_in) |->
            (pending_status_out & $past(cmd_data_in & is_edge)) == $past(cmd_data_in & is_edge);
    endproperty
    a_set_edge: assert property (p_set_edge) else $error("set lost");

    property p_eos_idle;
        @(posedge clk_in) disable iff (rst_in)
        end_of_service_wr_in && !vector_rd_in && depth == 4'h0 |=> !in_srv_q;
    endproperty
    a_eos_idle: assert property (p_eos_idle) else $error("service not ended");

    property p_best_wins;
        @(posedge clk_in) disable iff (rst_in)
        s_take |-> cand[best] && beaten == 32'h0000_0000;
    endproperty
    a_best_wins: assert property (p_best_wins) else $error("outranked source taken");

    property p_empty_read;
        @(posedge clk_in) disable iff (rst_in)
        vector_rd_in && cand == 32'h0000_0000 && !end_of_service_wr_in |=>
            $stable(current_source_out) && $stable(vector_data_out);
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("empty read changed state");

    property p_service_quiet;
        @(posedge clk_in) disable iff (rst_in)
        in_srv_q && !vector_rd_in && !end_of_service_wr_in && above == 32'h0000_0000 |=>
            normal_request_n_out;
    endproperty
    a_service_quiet: assert property (p_service_quiet) else $error("request not higher");

    property p_service_outranked;
        @(posedge clk_in) disable iff (rst_in)
        in_srv_q && !vector_rd_in && !end_of_service_wr_in && above != 32'h0000_0000 |=>
            !normal_request_n_out;
    endproperty
    a_service_outranked: assert property (p_service_outranked) else $error("higher ignored");

    property p_depth_limit;
        @(posedge clk_in) disable iff (rst_in)
        depth <= 4'h8;
    endproperty
    a_depth_limit: assert property (p_depth_limit) else $error("stack overrun");

    property p_full_drop;
        @(posedge clk_in) disable iff (rst_in)
        s_take ##0 in_srv_q && depth == 4'h8 |=> depth == 4'h8;
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full stack grew");

    property p_pop_depth;
        @(posedge clk_in) disable iff (rst_in)
        s_pop_nonempty |=> depth == $past(depth) - 4'h1;
    endproperty
    a_pop_depth: assert property (p_pop_depth) else $error("stack not popped");

    property p_forced_fast;
        @(posedge clk_in) disable iff (rst_in)
        (pend & mask_q & fast_force_in) != 32'h0000_0000 |=> !fast_request_n_out;
    endproperty
    a_forced_fast: assert property (p_forced_fast) else $error("forced source not fast");

endmodule

// File: rtl/vpic_pkg.sv
// Purpose: shared constants, types and functions of the vectored interrupt controller
// Assumes: 32 sources, eight priority levels, one 100 MHz clock
// Notes: trigger codes shared by all source stages
package vpic_pkg;

    localparam int NUM_SRC = 32;
    localparam int PRIO_W = 3;
    localparam int SRC_W = 5;
    localparam int STACK_DEPTH = 8;
    localparam int DEPTH_W = 4;

    // Sources wired to pins rather than on-chip logic
    localparam logic [31:0] EXT_SRC_MASK = 32'hC000_0001;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [PRIO_W-1:0] LEVEL_RESET = 3'h0;
    localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;
    localparam logic [SRC_W-1:0] FAST_SRC = 5'h00;

    // Trigger field: bit 0 selects edge, bit 1 selects active-high
    localparam logic [1:0] TRIG_LOW_LEVEL = 2'h0;
    localparam logic [1:0] TRIG_FALL_EDGE = 2'h1;
    localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h2;
    localparam logic [1:0] TRIG_RISE_EDGE = 2'h3;
    localparam int TRIG_EDGE_BIT = 0;
    localparam int TRIG_POL_BIT = 1;

    typedef logic [SRC_W+PRIO_W-1:0] vpic_entry_t;

    // Priority of one source out of the packed field vector
    function automatic logic [PRIO_W-1:0] vpic_prio(input logic [95:0] pv, input int idx);
        vpic_prio = pv[idx*PRIO_W +: PRIO_W];
    endfunction

    // Highest level wins, lowest number among equals
    function automatic logic [SRC_W-1:0] vpic_best(input logic [31:0] cand,
                                                  input logic [95:0] pv);
        logic [SRC_W-1:0] b;
        logic [PRIO_W-1:0] bl;
        logic found;
        b = SRC_RESET;
        bl = LEVEL_RESET;
        found = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (cand[i] && (!found || vpic_prio(pv, i) > bl)) begin
                b = SRC_W'(i);
                bl = vpic_prio(pv, i);
                found = 1'b1;
            end
        end
        vpic_best = b;
    endfunction

endpackage

// File: rtl/vpic_src_stage.sv
// Purpose: input stage of one interrupt source
// Assumes: set and clear are one-cycle strobes on clk_in
// Notes: external stages carry a two-flop synchroniser
`timescale 1ns/1ps
module vpic_src_stage #(
    parameter bit IS_EXT = 1'b0
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Source and control
    input wire logic raw_in,
    input wire logic [1:0] trig_in,
    input wire logic set_in,
    input wire logic clr_in,
    // Detected activity
    output logic pend_out,
    output logic is_edge_out
);
    import vpic_pkg::*;

    logic sync1_q, sync2_q, prev_q, prev_d, latch_q, latch_d, lvl, active, is_edge;

    // Pin synchroniser
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    always_comb begin
        lvl = IS_EXT ? sync2_q : raw_in;
        is_edge = trig_in[TRIG_EDGE_BIT];
        // Internal sources are always active high
        active = (IS_EXT && !trig_in[TRIG_POL_BIT]) ? !lvl : lvl;
        prev_d = active;
        latch_d = latch_q;
        if (!is_edge) begin
            latch_d = 1'b0;
        end else begin
            if (clr_in) begin
                latch_d = 1'b0;
            end
            if (set_in || (active && !prev_q)) begin
                latch_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prev_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            latch_q <= latch_d;
        end
    end

    assign pend_out = is_edge ? latch_q : active;
    assign is_edge_out = is_edge;

endmodule

// File: rtl/vpic_stack.sv
// Purpose: nesting stack of source number and level
// Assumes: push and pop never in the same cycle
// Notes: push when full is dropped
`timescale 1ns/1ps
module vpic_stack (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Stack access
    input wire logic push_in,
    input wire logic pop_in,
    input wire vpic_pkg::vpic_entry_t push_data_in,
    output vpic_pkg::vpic_entry_t top_out,
    output logic [vpic_pkg::DEPTH_W-1:0] depth_out
);
    import vpic_pkg::*;

    vpic_entry_t mem_q [STACK_DEPTH];
    vpic_entry_t mem_d [STACK_DEPTH];
    logic [DEPTH_W-1:0] depth_q, depth_d;

    always_comb begin
        mem_d = mem_q;
        depth_d = depth_q;
        if (push_in && depth_q < DEPTH_W'(STACK_DEPTH)) begin
            mem_d[depth_q[2:0]] = push_data_in;
            depth_d = depth_q + 4'h1;
        end else if (pop_in && depth_q != 4'h0) begin
            depth_d = depth_q - 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            depth_q <= 4'h0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            depth_q <= depth_d;
            mem_q <= mem_d;
        end
    end

    assign top_out = (depth_q == 4'h0) ? '0 : mem_q[3'(depth_q - 4'h1)];
    assign depth_out = depth_q;

endmodule
